// ==== logic/core_state_pkg.sv ====
// Package for the core state register block: data-space addresses,
// widths, reset values and the command and context encodings.
// Assumes one core clock and an 8-bit internal data-space bus.
package core_state_pkg;

  localparam int          DATA_W      = 8;
  localparam int          PC_W        = 12;
  localparam int          STACK_DEPTH = 6;

  // ----------------------------------------------------------------
  // Data-space addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_INDEX_POINTER_A = 8'h80;
  localparam logic [7:0]  ADDR_INDEX_POINTER_B = 8'h81;
  localparam logic [7:0]  ADDR_SHORT_DIRECT_A  = 8'h82;
  localparam logic [7:0]  ADDR_SHORT_DIRECT_B  = 8'h83;
  localparam logic [7:0]  ADDR_ACCUMULATOR     = 8'hff;

  // ----------------------------------------------------------------
  // Reset values and stack level limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [11:0] PC_RESET    = 12'h000;
  localparam logic [2:0]  LEVEL_EMPTY = 3'h0;
  localparam logic [2:0]  LEVEL_FULL  = 3'h6;

  // Program counter commands from the sequencer.
  typedef enum logic [2:0] {
    PC_HOLD,
    PC_INCR,
    PC_RELATIVE,
    PC_JUMP,
    PC_CALL,
    PC_IRQ,
    PC_NMI,
    PC_RETURN
  } pc_cmd_e;

  // Execution contexts owning one flag pair each.
  typedef enum logic [1:0] {
    CTX_NORMAL,
    CTX_IRQ,
    CTX_NONMASKABLE
  } ctx_e;

  typedef struct packed {
    logic carry;
    logic zero;
  } flag_pair_s;

  // Flag update request for the active pair.
  typedef struct packed {
    logic carry_we;
    logic carry_val;
    logic zero_we;
    logic zero_val;
  } flag_upd_s;

  // Data-space access from the core bus.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ds_req_s;

endpackage : core_state_pkg

// ==== logic/cpu_core_state_registers.sv ====
// Programmer-visible core state: accumulator, pointer and short-direct
// registers, program counter, three flag pairs and the return stack.
// Assumes the sequencer issues one command per cycle on the core clock.
`timescale 1ns/1ps

module cpu_core_state_registers #(
  parameter logic [11:0] RESET_VECTOR = 12'hffe,
  parameter logic [11:0] NMI_VECTOR   = 12'hffc
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire core_state_pkg::ds_req_s       ds_req,
  output logic [7:0]                         ds_rdata,
  output logic                               ds_hit,
  input  wire logic                          acc_we,
  input  wire logic [7:0]                    acc_wdata,
  input  wire core_state_pkg::pc_cmd_e       pc_cmd,
  input  wire logic [7:0]                    rel_offset,
  input  wire logic [11:0]                   target_addr,
  input  wire logic [11:0]                   irq_vector,
  input  wire core_state_pkg::flag_upd_s     flag_upd,
  output logic [7:0]                         accumulator,
  output logic [7:0]                         index_pointer_a,
  output logic [7:0]                         index_pointer_b,
  output logic [7:0]                         short_direct_a,
  output logic [7:0]                         short_direct_b,
  output logic [11:0]                        program_counter,
  output core_state_pkg::flag_pair_s         active_flags,
  output core_state_pkg::ctx_e               active_ctx,
  output logic [2:0]                         stack_level
);

  typedef struct packed {
    logic [7:0]                   acc;
    logic [7:0]                   ptr_a;
    logic [7:0]                   ptr_b;
    logic [7:0]                   sd_a;
    logic [7:0]                   sd_b;
    logic [11:0]                  pc;
    core_state_pkg::flag_pair_s   fl_norm;
    core_state_pkg::flag_pair_s   fl_irq;
    core_state_pkg::flag_pair_s   fl_nmi;
    core_state_pkg::ctx_e         ctx;
    core_state_pkg::ctx_e         ctx_saved;
    logic [5:0][11:0]             stack;
    logic [2:0]                   depth;
    logic [7:0]                   rdata;
    logic                         hit;
    core_state_pkg::flag_pair_s   act;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // ----------------------------------------------------------------
  // Behaviour in brief
  // ----------------------------------------------------------------
  // The whole programmer-visible state lives in one record so that a
  // single clocked process owns it and reset covers every field.
  //
  // Data space: the five mapped registers answer one cycle after the
  // address is presented. A read and a write to the same location in
  // one cycle return the old value, because the read path samples the
  // registered copy before the write is applied.
  //
  // Accumulator: the ALU result port and the data-space port may both
  // target it in one cycle. The ALU port wins, since an instruction
  // that computes into the accumulator must not lose its result to a
  // stray bus write.
  //
  // Program counter: exactly one command per cycle. The sequencer is
  // expected to have advanced the counter before a call or interrupt,
  // so the value pushed is already the return address.
  //
  // Return stack: six levels, shifted as a whole. The depth counter
  // only records how many levels hold valid addresses; software never
  // sees it as a pointer. A push when full still shifts, so the oldest
  // address falls off the far end. A pop when empty behaves as a plain
  // increment and leaves the levels untouched.
  //
  // Contexts: one saved context only. A nonmaskable entry on top of a
  // maskable one overwrites the saved value, so the second return stays in
  // the maskable context, since the saved value still names it. Nested use beyond
  // one level is the sequencer's responsibility.
  //
  // Flags: each context owns a pair, and only the pair in force at the
  // clock edge is updated. The pair shown on the output is registered
  // together with the context it belongs to, so output and selector
  // never disagree for a cycle.

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == core_state_pkg::ADDR_ACCUMULATOR) ||
                (a == core_state_pkg::ADDR_INDEX_POINTER_A) ||
                (a == core_state_pkg::ADDR_INDEX_POINTER_B) ||
                (a == core_state_pkg::ADDR_SHORT_DIRECT_A) ||
                (a == core_state_pkg::ADDR_SHORT_DIRECT_B);
  endfunction : is_mapped

  function automatic core_state_pkg::flag_pair_s apply_flags(
    input core_state_pkg::flag_pair_s cur,
    input core_state_pkg::flag_upd_s  upd
  );
    core_state_pkg::flag_pair_s r;
    r = cur;
    if (upd.carry_we) begin
      r.carry = upd.carry_val;
    end
    if (upd.zero_we) begin
      r.zero = upd.zero_val;
    end
    apply_flags = r;
  endfunction : apply_flags

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [11:0] pc_inc;
    logic        push;
    logic        pop;
    state_nxt = state_r;
    pc_inc    = state_r.pc + 12'h001;
    push      = 1'b0;
    pop       = 1'b0;

    // Data-space reads see the value before this cycle's write.
    state_nxt.hit   = is_mapped(ds_req.addr);
    state_nxt.rdata = 8'h00;
    unique case (ds_req.addr)
      core_state_pkg::ADDR_ACCUMULATOR:     state_nxt.rdata = state_r.acc;
      core_state_pkg::ADDR_INDEX_POINTER_A: state_nxt.rdata = state_r.ptr_a;
      core_state_pkg::ADDR_INDEX_POINTER_B: state_nxt.rdata = state_r.ptr_b;
      core_state_pkg::ADDR_SHORT_DIRECT_A:  state_nxt.rdata = state_r.sd_a;
      core_state_pkg::ADDR_SHORT_DIRECT_B:  state_nxt.rdata = state_r.sd_b;
      default:                              state_nxt.rdata = 8'h00;
    endcase

    if (ds_req.wr) begin
      unique case (ds_req.addr)
        core_state_pkg::ADDR_ACCUMULATOR:
          state_nxt.acc = ds_req.wdata;
        core_state_pkg::ADDR_INDEX_POINTER_A:
          state_nxt.ptr_a = ds_req.wdata;
        core_state_pkg::ADDR_INDEX_POINTER_B:
          state_nxt.ptr_b = ds_req.wdata;
        core_state_pkg::ADDR_SHORT_DIRECT_A:
          state_nxt.sd_a = ds_req.wdata;
        core_state_pkg::ADDR_SHORT_DIRECT_B:
          state_nxt.sd_b = ds_req.wdata;
        default: ;
      endcase
    end
    // The ALU result port wins over a same-cycle data-space write.
    if (acc_we) begin
      state_nxt.acc = acc_wdata;
    end

    // Flags: only the pair of the context in force this cycle.
    unique case (state_r.ctx)
      core_state_pkg::CTX_NORMAL:
        state_nxt.fl_norm = apply_flags(state_r.fl_norm, flag_upd);
      core_state_pkg::CTX_IRQ:
        state_nxt.fl_irq = apply_flags(state_r.fl_irq, flag_upd);
      core_state_pkg::CTX_NONMASKABLE:
        state_nxt.fl_nmi = apply_flags(state_r.fl_nmi, flag_upd);
      default: ;
    endcase

    unique case (pc_cmd)
      core_state_pkg::PC_HOLD: ;
      core_state_pkg::PC_INCR:
        state_nxt.pc = pc_inc;
      core_state_pkg::PC_RELATIVE:
        state_nxt.pc = state_r.pc +
                       {{4{rel_offset[7]}}, rel_offset};
      core_state_pkg::PC_JUMP:
        state_nxt.pc = target_addr;
      core_state_pkg::PC_CALL: begin
        state_nxt.pc = target_addr;
        push         = 1'b1;
      end
      core_state_pkg::PC_IRQ: begin
        state_nxt.pc = irq_vector;
        push         = 1'b1;
        // Flags are not touched, only the selector moves.
        state_nxt.ctx       = core_state_pkg::CTX_IRQ;
        state_nxt.ctx_saved = state_r.ctx;
      end
      core_state_pkg::PC_NMI: begin
        state_nxt.pc = NMI_VECTOR;
        push         = 1'b1;
        state_nxt.ctx       = core_state_pkg::CTX_NONMASKABLE;
        state_nxt.ctx_saved = state_r.ctx;
      end
      core_state_pkg::PC_RETURN: begin
        pop = 1'b1;
      end
    endcase

    // The counter pushed is the already advanced return address.
    if (push) begin
      for (int i = core_state_pkg::STACK_DEPTH - 1; i > 0; i--) begin
        state_nxt.stack[i] = state_r.stack[i-1];
      end
      state_nxt.stack[0] = state_r.pc;
      if (state_r.depth != core_state_pkg::LEVEL_FULL) begin
        state_nxt.depth = state_r.depth + 3'h1;
      end
    end

    if (pop) begin
      if (state_r.depth == core_state_pkg::LEVEL_EMPTY) begin
        state_nxt.pc = pc_inc;
      end else begin
        state_nxt.pc    = state_r.stack[0];
        state_nxt.depth = state_r.depth - 3'h1;
        for (int i = 0; i < core_state_pkg::STACK_DEPTH - 1; i++) begin
          state_nxt.stack[i] = state_r.stack[i+1];
        end
      end
      // The return opcode also ends an interrupt context.
      state_nxt.ctx = state_r.ctx_saved;
    end

    // Registered copy of the pair that will be in force next cycle.
    unique case (state_nxt.ctx)
      core_state_pkg::CTX_NORMAL: state_nxt.act = state_nxt.fl_norm;
      core_state_pkg::CTX_IRQ:    state_nxt.act = state_nxt.fl_irq;
      default:                    state_nxt.act = state_nxt.fl_nmi;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r           <= '0;
      state_r.pc        <= RESET_VECTOR;
      state_r.ctx       <= core_state_pkg::CTX_NONMASKABLE;
      state_r.ctx_saved <= core_state_pkg::CTX_NORMAL;
      state_r.depth     <= core_state_pkg::LEVEL_EMPTY;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign ds_rdata        = state_r.rdata;
  assign ds_hit          = state_r.hit;
  assign accumulator     = state_r.acc;
  assign index_pointer_a = state_r.ptr_a;
  assign index_pointer_b = state_r.ptr_b;
  assign short_direct_a  = state_r.sd_a;
  assign short_direct_b  = state_r.sd_b;
  assign program_counter = state_r.pc;
  assign active_ctx      = state_r.ctx;
  assign stack_level     = state_r.depth;
  assign active_flags    = state_r.act;

endmodule : cpu_core_state_registers

// ==== tb/core_state_props.sv ====
// Checker for the core state block: counter, stack, context and flags.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/1ps
module core_state_props #(
  parameter logic [11:0] NMI_VECTOR = 12'hffc
) (
  input wire logic                       clk,
  input wire logic                       sys_rst,
  input wire core_state_pkg::ds_req_s    ds_req,
  input wire logic [7:0]                 ds_rdata,
  input wire logic                       acc_we,
  input wire core_state_pkg::pc_cmd_e    pc_cmd,
  input wire logic [7:0]                 rel_offset,
  input wire logic [11:0]                target_addr,
  input wire logic [11:0]                irq_vector,
  input wire core_state_pkg::flag_upd_s  flag_upd,
  input wire logic [7:0]                 accumulator,
  input wire logic [11:0]                program_counter,
  input wire core_state_pkg::flag_pair_s active_flags,
  input wire core_state_pkg::ctx_e       active_ctx,
  input wire logic [2:0]                 stack_level
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_call;
    pc_cmd == core_state_pkg::PC_CALL;
  endsequence
  sequence s_ret;
    pc_cmd == core_state_pkg::PC_RETURN;
  endsequence
  a_pc_step: assert property (pc_cmd == core_state_pkg::PC_INCR |=>
    program_counter == $past(program_counter) + 12'h001)
    else $error("counter did not step by one");
  a_pc_rel: assert property (pc_cmd == core_state_pkg::PC_RELATIVE |=>
    program_counter == $past(program_counter)
      + {{4{$past(rel_offset[7])}}, $past(rel_offset)})
    else $error("relative branch sum wrong");
  a_push_deeper: assert property (s_call ##0 stack_level < 3'h6 |=>
    stack_level == $past(stack_level) + 3'h1
      && program_counter == $past(target_addr))
    else $error("call did not push");
  a_push_full: assert property (s_call ##0 stack_level == 3'h6 |=>
    stack_level == 3'h6)
    else $error("full stack left deepest level");
  a_pop_empty: assert property (s_ret ##0 stack_level == 3'h0 |=>
    stack_level == 3'h0 && program_counter == $past(program_counter) + 12'h001)
    else $error("empty return not sequential");
  a_call_return: assert property (s_call ##1 s_ret |=>
    program_counter == $past(program_counter, 2))
    else $error("return address lost");
  a_irq_entry: assert property (pc_cmd == core_state_pkg::PC_IRQ |=>
    active_ctx == core_state_pkg::CTX_IRQ && program_counter == $past(irq_vector))
    else $error("interrupt entry wrong");
  a_nmi_entry: assert property (pc_cmd == core_state_pkg::PC_NMI |=>
    active_ctx == core_state_pkg::CTX_NONMASKABLE
      && program_counter == NMI_VECTOR)
    else $error("nonmaskable entry wrong");
  a_flag_write: assert property (pc_cmd == core_state_pkg::PC_HOLD
    && flag_upd.carry_we && flag_upd.zero_we |=>
    active_flags == $past({flag_upd.carry_val, flag_upd.zero_val}))
    else $error("active flags not written");
  a_acc_read: assert property (ds_req.addr == 8'hff && !ds_req.wr
    && !acc_we |=> ds_rdata == $past(accumulator))
    else $error("accumulator read wrong");
endmodule : core_state_props

bind cpu_core_state_registers core_state_props #(.NMI_VECTOR(NMI_VECTOR)) u_props (
  .clk, .sys_rst, .ds_req, .ds_rdata, .acc_we, .pc_cmd, .rel_offset,
  .target_addr, .irq_vector, .flag_upd, .accumulator, .program_counter,
  .active_flags, .active_ctx, .stack_level);

// ==== tb/core_sequencer_model.sv ====
// Sequencer stand-in: one counter command and flag update per cycle.
// Assumes the bench calls step from its main process only.
`timescale 1ns/1ps
module core_sequencer_model (
  input  wire logic                 clk,
  output core_state_pkg::pc_cmd_e   pc_cmd,
  output logic [7:0]                rel_offset,
  output logic [11:0]               target_addr,
  output logic [11:0]               irq_vector,
  output core_state_pkg::flag_upd_s flag_upd
);
  initial begin
    pc_cmd = core_state_pkg::PC_HOLD;
    rel_offset = 8'h00;
    target_addr = 12'h000;
    irq_vector = 12'h000;
    flag_upd = '0;
  end
  // Handler code keeps data registers itself; only addresses are stacked.
  task automatic step(input core_state_pkg::pc_cmd_e cmd,
                      input logic [11:0] arg, input logic [3:0] upd);
    @(posedge clk);
    pc_cmd <= cmd;
    target_addr <= arg;
    irq_vector <= arg;
    rel_offset <= arg[7:0];
    flag_upd <= upd;
  endtask : step
endmodule : core_sequencer_model

// ==== tb/cpu_core_state_registers_tb.sv ====
// Bench for the core state block: data space, counter, stack and flags.
// Assumes the sequencer model drives all command inputs.
`timescale 1ns/1ps
module cpu_core_state_registers_tb;
  localparam logic [11:0] RV = 12'hffe;
  localparam logic [11:0] NV = 12'hffc;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic acc_we = 1'b0;
  logic [7:0] acc_wdata = 8'h00;
  core_state_pkg::ds_req_s ds_req = '0;
  logic [7:0] ds_rdata, accumulator, ipa, rel_offset;
  logic [7:0] ipb, sda, sdb;
  logic ds_hit;
  logic [11:0] target_addr, irq_vector, pc;
  logic [2:0] lvl;
  core_state_pkg::pc_cmd_e pc_cmd;
  core_state_pkg::flag_upd_s flag_upd;
  core_state_pkg::flag_pair_s fl;
  core_state_pkg::ctx_e ctx;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [7:0] adr [6] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'h84};
  always #5 clk = ~clk;
  core_sequencer_model seq (.clk, .pc_cmd, .rel_offset, .target_addr,
    .irq_vector, .flag_upd);
  cpu_core_state_registers #(.RESET_VECTOR(RV), .NMI_VECTOR(NV)) dut (
    .clk, .sys_rst, .ds_req, .ds_rdata, .ds_hit, .acc_we, .acc_wdata,
    .pc_cmd, .rel_offset, .target_addr, .irq_vector, .flag_upd,
    .accumulator, .index_pointer_a(ipa), .index_pointer_b(ipb),
    .short_direct_a(sda), .short_direct_b(sdb), .program_counter(pc),
    .active_flags(fl), .active_ctx(ctx), .stack_level(lvl));
  task automatic chk(input string what, input logic [11:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic ds_put(input logic wr, input logic [7:0] a, d);
    @(posedge clk);
    ds_req <= {wr, a, d};
  endtask : ds_put
  task automatic settle;
    seq.step(core_state_pkg::PC_HOLD, 12'h000, 4'h0);
    #1;
  endtask : settle
  task automatic do_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : do_reset
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
  initial begin
    do_reset;
    #1;
    chk("ctx", core_state_pkg::CTX_NONMASKABLE, ctx);
    chk("pc", RV, pc);
    seq.step(core_state_pkg::PC_HOLD, 12'h000, 4'hf);
    seq.step(core_state_pkg::PC_IRQ, 12'h040, 4'h0);
    settle;
    chk("ctx", core_state_pkg::CTX_IRQ, ctx);
    chk("flags", 12'h000, fl);
    seq.step(core_state_pkg::PC_HOLD, 12'h000, 4'hc);
    seq.step(core_state_pkg::PC_RETURN, 12'h000, 4'h0);
    settle;
    chk("ctx", core_state_pkg::CTX_NONMASKABLE, ctx);
    chk("flags", 12'h003, fl);
    seq.step(core_state_pkg::PC_IRQ, 12'h040, 4'h0);
    settle;
    chk("flags", 12'h002, fl);
    seq.step(core_state_pkg::PC_NMI, 12'h000, 4'h0);
    settle;
    chk("pc", NV, pc);
    for (int i = 0; i < 6; i++) begin
      ds_put(1'b1, adr[i], 8'h5a + 8'(i));
      ds_put(1'b0, adr[i], 8'h00);
      @(posedge clk);
      #1;
      chk("rdata", (i < 5) ? 8'h5a + 8'(i) : 8'h00, ds_rdata);
      chk("hit", (i < 5), ds_hit);
    end
    chk("ptr", 8'h5a, ipa);
    chk("ptr_b", 8'h5b, ipb);
    chk("sd_a", 8'h5c, sda);
    chk("sd_b", 8'h5d, sdb);
    chk("acc", 8'h5e, accumulator);
    ds_put(1'b1, 8'hff, 8'h33);
    acc_we <= 1'b1;
    acc_wdata <= 8'h77;
    ds_put(1'b0, 8'hff, 8'h00);
    acc_we <= 1'b0;
    #1;
    chk("acc", 8'h77, accumulator);
    do_reset;
    seq.step(core_state_pkg::PC_JUMP, 12'hfff, 4'h0);
    seq.step(core_state_pkg::PC_INCR, 12'h000, 4'h0);
    settle;
    chk("pc", 12'h000, pc);
    seq.step(core_state_pkg::PC_RELATIVE, 12'h0fe, 4'h0);
    settle;
    chk("pc", 12'hffe, pc);
    for (int i = 0; i < 7; i++)
      seq.step(core_state_pkg::PC_CALL, 12'h100 + 12'(i), 4'h0);
    settle;
    chk("level", 12'h006, lvl);
    for (int i = 0; i < 7; i++) begin
      seq.step(core_state_pkg::PC_RETURN, 12'h000, 4'h0);
      settle;
      chk("pc", (i < 6) ? 12'h105 - 12'(i) : 12'h101, pc);
      chk("level", 12'((i < 6) ? 5 - i : 0), lvl);
    end
    seq.step(core_state_pkg::PC_CALL, 12'h200, 4'h0);
    seq.step(core_state_pkg::PC_RETURN, 12'h000, 4'h0);
    settle;
    chk("pc", 12'h101, pc);
    close_out;
  end
endmodule : cpu_core_state_registers_tb
